// >>> mdmr_flash_model.sv
// mdmr_flash_model: flash engine stand-in counting program and erase strobes.
// assumes one-cycle strobes; counts survive a router reset on purpose.
`timescale 1ns/100ps
`default_nettype none
module mdmr_flash_model (
  input wire logic clk_i,
  input wire logic prog_i,
  input wire logic erase_i,
  output logic [7:0] n_prog_o = 8'h00,
  output logic [7:0] n_erase_o = 8'h00
);
  always @(posedge clk_i) begin
    if (prog_i) n_prog_o <= n_prog_o + 8'h01;
    if (erase_i) n_erase_o <= n_erase_o + 8'h01;
  end
endmodule
`default_nettype wire

// >>> mdmr_pkg.sv
// mdmr_pkg: constants shared by the external-move data memory router.
// assumes the core presents special-function register accesses as byte
// writes and reads on a single-cycle port.
package mdmr_pkg;

  // ----------------------------------------------------------------
  // special function register addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] MDMR_PSC_ADDR = 8'h8f;
  localparam logic [7:0] MDMR_FTS_ADDR = 8'hb6;
  localparam logic [7:0] MDMR_PAGE_ADDR = 8'haa;

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int MDMR_WE_BIT = 0;
  localparam int MDMR_EE_BIT = 1;
  localparam logic [7:0] MDMR_PSC_RESET = 8'h00;
  localparam logic [7:0] MDMR_FTS_RESET = 8'h00;
  localparam logic [7:0] MDMR_PAGE_RESET = 8'h00;
  localparam int MDMR_PAGE_BITS = 3;

  // ----------------------------------------------------------------
  // memory geometry
  // ----------------------------------------------------------------
  localparam int MDMR_RAM_AW = 11;
  localparam logic [15:0] MDMR_USER_TOP = 16'h03ff;
  localparam logic [15:0] MDMR_FIFO_BASE = 16'h0400;
  localparam logic [15:0] MDMR_FIFO_TOP = 16'h07ff;

  // ----------------------------------------------------------------
  // access routing
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    MDMR_RT_RAM = 3'b001,
    MDMR_RT_PROG = 3'b010,
    MDMR_RT_ERASE = 3'b100
  } mdmr_route_t;

endpackage

// >>> mdmr_ram.sv
// mdmr_ram: single-port byte RAM backing the external data space.
// assumes one access per cycle; read data valid the cycle after the read.
`timescale 1ns/100ps
`default_nettype none
module mdmr_ram #(
  parameter int AW = 11
) (
  input wire logic clk_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [AW-1:0] addr_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] rdata_o
);
  logic [7:0] mem [0:(1<<AW)-1];

  // no reset on the array: contents are undefined after power-up
  always_ff @(posedge clk_i) begin
    if (wr_i) begin
      mem[addr_i] <= wdata_i;
    end
    if (rd_i) begin
      rdata_o <= mem[addr_i];
    end
  end
endmodule
`default_nettype wire

// >>> mdmr_router.sv
// mdmr_router: decodes external-move accesses onto the data RAM or, while
// flash writing is enabled and the supply monitor is up, writes onto the flash
// programming engine; with the monitor down such writes raise the error reset.
// assumes the core holds each access request for one cycle and the flash
// engine accepts one-cycle program and erase strobes.
`timescale 1ns/100ps
`default_nettype none
module mdmr_router
  import mdmr_pkg::*;
#(
  parameter int RAM_AW = MDMR_RAM_AW
) (
  input wire logic CLK_I,
  input wire logic RESETN_I,
  // special function register port
  input wire logic SFR_WR_I,
  input wire logic SFR_RD_I,
  input wire logic [7:0] SFR_ADDR_I,
  input wire logic [7:0] SFR_WDATA_I,
  output logic [7:0] SFR_RDATA_O,
  // external-move port
  input wire logic XM_WR_I,
  input wire logic XM_RD_I,
  input wire logic XM_SHORT_I,
  input wire logic [15:0] XM_ADDR_I,
  input wire logic [7:0] XM_WDATA_I,
  output logic [7:0] XM_RDATA_O,
  output logic XM_RVALID_O,
  output logic XM_FIFO_HIT_O,
  // supply monitor state
  input wire logic MON_EN_I,
  input wire logic MON_RST_EN_I,
  // flash programming engine
  output logic FL_PROG_O,
  output logic FL_ERASE_O,
  output logic [15:0] FL_ADDR_O,
  output logic [7:0] FL_DATA_O,
  output logic FLASH_ERROR_RESET_O,
  output logic FLASH_WRITE_ENABLE_O,
  output logic FLASH_ERASE_ENABLE_O,
  output logic [7:0] FLASH_TIMING_SCALE_O
);
  import mdmr_pkg::*;

  // ----------------------------------------------------------------
  // elaboration check
  // ----------------------------------------------------------------
  // the page field and the alias both assume a 2048-byte array
  if (RAM_AW != MDMR_RAM_AW) begin : g_bad_ram_aw
    $error("mdmr_router: RAM_AW must be 11");
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic flash_write_enable;
  logic flash_erase_enable;
  logic [7:0] flash_timing_scale;
  logic [MDMR_PAGE_BITS-1:0] ram_page_select;

  // one compare shape for every register decode
  function automatic logic sfr_hit(
    input logic [7:0] addr,
    input logic [7:0] target
  );
    sfr_hit = addr == target;
  endfunction

  wire sel_psc = sfr_hit(SFR_ADDR_I, MDMR_PSC_ADDR);
  wire sel_fts = sfr_hit(SFR_ADDR_I, MDMR_FTS_ADDR);
  wire sel_page = sfr_hit(SFR_ADDR_I, MDMR_PAGE_ADDR);

  wire [7:0] psc_view = {6'h00, flash_erase_enable, flash_write_enable};
  wire [7:0] page_view = {5'h00, ram_page_select};
  wire [7:0] next_sfr_rdata = sel_psc ? psc_view :
                              sel_fts ? flash_timing_scale :
                              sel_page ? page_view : 8'h00;

  // ----------------------------------------------------------------
  // address formation
  // ----------------------------------------------------------------
  // short form: page supplies address bits 10:8, bits 15:11 are zero
  wire [15:0] full_addr = XM_SHORT_I ?
                          {5'h00, ram_page_select, XM_ADDR_I[7:0]} :
                          XM_ADDR_I;
  wire [RAM_AW-1:0] ram_addr = full_addr[RAM_AW-1:0];
  wire fifo_hit = {5'h00, ram_addr} >= MDMR_FIFO_BASE;
  wire xm_any = XM_RD_I || XM_WR_I;

  // ----------------------------------------------------------------
  // routing
  // ----------------------------------------------------------------
  // RAM by default
  wire mdmr_route_t route = !flash_write_enable ? MDMR_RT_RAM :
                            flash_erase_enable ? MDMR_RT_ERASE :
                            MDMR_RT_PROG;
  wire mon_ok = MON_EN_I && MON_RST_EN_I;
  wire to_ram = route == MDMR_RT_RAM;
  wire ram_wr = XM_WR_I && to_ram;
  // reads stay on RAM; only writes are diverted to flash
  wire ram_rd = XM_RD_I;
  wire fl_req = XM_WR_I && !to_ram;
  wire next_error = fl_req && !mon_ok;
  wire next_prog = fl_req && mon_ok && route == MDMR_RT_PROG;
  wire next_erase = fl_req && mon_ok && route == MDMR_RT_ERASE;

  logic [7:0] ram_rdata;

  mdmr_ram #(
    .AW(RAM_AW)
  ) u_ram (
    .clk_i(CLK_I),
    .wr_i(ram_wr),
    .rd_i(ram_rd),
    .addr_i(ram_addr),
    .wdata_i(XM_WDATA_I),
    .rdata_o(ram_rdata)
  );

  assign XM_RDATA_O = ram_rdata;

  // ----------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_I) begin
    if (!RESETN_I) begin
      flash_write_enable <= MDMR_PSC_RESET[MDMR_WE_BIT];
      flash_erase_enable <= MDMR_PSC_RESET[MDMR_EE_BIT];
      flash_timing_scale <= MDMR_FTS_RESET;
      ram_page_select <= MDMR_PAGE_RESET[MDMR_PAGE_BITS-1:0];
    end else if (SFR_WR_I) begin
      if (sel_psc) begin
        flash_write_enable <= SFR_WDATA_I[MDMR_WE_BIT];
        flash_erase_enable <= SFR_WDATA_I[MDMR_EE_BIT];
      end
      if (sel_fts) begin
        flash_timing_scale <= SFR_WDATA_I;
      end
      if (sel_page) begin
        ram_page_select <= SFR_WDATA_I[MDMR_PAGE_BITS-1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // register read data
  // ----------------------------------------------------------------
  // read data holds between reads so a slow core can take it late
  always_ff @(posedge CLK_I) begin
    if (!RESETN_I) begin
      SFR_RDATA_O <= 8'h00;
    end else if (SFR_RD_I) begin
      SFR_RDATA_O <= next_sfr_rdata;
    end
  end

  // ----------------------------------------------------------------
  // external-move status
  // ----------------------------------------------------------------
  // read answer strobe
  always_ff @(posedge CLK_I) begin
    if (!RESETN_I) begin
      XM_RVALID_O <= 1'b0;
    end else begin
      XM_RVALID_O <= ram_rd;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RESETN_I) begin
      XM_FIFO_HIT_O <= 1'b0;
    end else begin
      XM_FIFO_HIT_O <= xm_any && fifo_hit;
    end
  end

  // ----------------------------------------------------------------
  // flash engine strobes
  // ----------------------------------------------------------------
  // one-cycle program and erase
  always_ff @(posedge CLK_I) begin
    if (!RESETN_I) begin
      FL_PROG_O <= 1'b0;
      FL_ERASE_O <= 1'b0;
    end else begin
      FL_PROG_O <= next_prog;
      FL_ERASE_O <= next_erase;
    end
  end

  // address and data hold for the engine until the next request
  always_ff @(posedge CLK_I) begin
    if (!RESETN_I) begin
      FL_ADDR_O <= 16'h0000;
      FL_DATA_O <= 8'h00;
    end else if (fl_req) begin
      FL_ADDR_O <= full_addr;
      FL_DATA_O <= XM_WDATA_I;
    end
  end

  // sticky error reset
  // held until reset recovers the device; the reset itself is outside
  always_ff @(posedge CLK_I) begin
    if (!RESETN_I) begin
      FLASH_ERROR_RESET_O <= 1'b0;
    end else if (next_error) begin
      FLASH_ERROR_RESET_O <= 1'b1;
    end
  end

  assign FLASH_WRITE_ENABLE_O = flash_write_enable;
  assign FLASH_ERASE_ENABLE_O = flash_erase_enable;
  assign FLASH_TIMING_SCALE_O = flash_timing_scale;
endmodule
`default_nettype wire

// >>> mdmr_router_checker.sv
// mdmr_router_checker: port assertions for the data memory router.
// assumes a bind onto mdmr_router; single clock, sync active-low reset.
`timescale 1ns/100ps
`default_nettype none
module mdmr_router_checker
  import mdmr_pkg::*;
(
  input wire logic CLK_I,
  input wire logic RESETN_I,
  input wire logic SFR_WR_I,
  input wire logic SFR_RD_I,
  input wire logic [7:0] SFR_ADDR_I,
  input wire logic [7:0] SFR_WDATA_I,
  input wire logic [7:0] SFR_RDATA_O,
  input wire logic XM_WR_I,
  input wire logic XM_RD_I,
  input wire logic XM_SHORT_I,
  input wire logic [15:0] XM_ADDR_I,
  input wire logic [7:0] XM_WDATA_I,
  input wire logic XM_RVALID_O,
  input wire logic XM_FIFO_HIT_O,
  input wire logic MON_EN_I,
  input wire logic MON_RST_EN_I,
  input wire logic FL_PROG_O,
  input wire logic FL_ERASE_O,
  input wire logic [15:0] FL_ADDR_O,
  input wire logic [7:0] FL_DATA_O,
  input wire logic FLASH_ERROR_RESET_O,
  input wire logic FLASH_WRITE_ENABLE_O,
  input wire logic FLASH_ERASE_ENABLE_O
);
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!RESETN_I);
  wire mon_ok = MON_EN_I && MON_RST_EN_I;
  // flash-bound write, full address form
  sequence s_fwr;
    XM_WR_I && FLASH_WRITE_ENABLE_O && !XM_SHORT_I;
  endsequence
  // flash-bound write with the monitor up, program or erase
  sequence s_prog;
    s_fwr ##0 (mon_ok && !FLASH_ERASE_ENABLE_O);
  endsequence
  sequence s_erase;
    s_fwr ##0 (mon_ok && FLASH_ERASE_ENABLE_O);
  endsequence
  AST_RVALID: assert property (XM_RD_I |=> XM_RVALID_O)
    else $error("read valid missing");
  AST_FIFO: assert property (XM_RD_I && !XM_SHORT_I |=>
    XM_FIFO_HIT_O == $past(XM_ADDR_I[10])) else $error("fifo hit wrong");
  AST_PROG: assert property (s_prog |=>
    FL_PROG_O && !FL_ERASE_O && FL_ADDR_O == $past(XM_ADDR_I) &&
    FL_DATA_O == $past(XM_WDATA_I)) else $error("program strobe wrong");
  AST_ERASE: assert property (s_erase |=>
    FL_ERASE_O && !FL_PROG_O) else $error("erase strobe wrong");
  AST_RAMW: assert property (XM_WR_I && !FLASH_WRITE_ENABLE_O |=>
    !FL_PROG_O && !FL_ERASE_O) else $error("ram write reached flash");
  AST_FERR: assert property (s_fwr ##0 !mon_ok |=>
    FLASH_ERROR_RESET_O && !FL_PROG_O && !FL_ERASE_O) else $error("no error");
  AST_STICKY: assert property (FLASH_ERROR_RESET_O |=>
    FLASH_ERROR_RESET_O) else $error("error reset dropped");
  AST_RSVD: assert property (SFR_RD_I && SFR_ADDR_I == MDMR_PSC_ADDR |=>
    SFR_RDATA_O == {6'h00, FLASH_ERASE_ENABLE_O, FLASH_WRITE_ENABLE_O})
    else $error("control readback wrong");
  AST_PSCW: assert property (SFR_WR_I && SFR_ADDR_I == MDMR_PSC_ADDR |=>
    FLASH_WRITE_ENABLE_O == $past(SFR_WDATA_I[MDMR_WE_BIT]))
    else $error("write enable not taken");
endmodule
bind mdmr_router mdmr_router_checker mdmr_router_checker_i (
  .CLK_I(CLK_I), .RESETN_I(RESETN_I), .SFR_WR_I(SFR_WR_I),
  .SFR_RD_I(SFR_RD_I), .SFR_ADDR_I(SFR_ADDR_I), .SFR_WDATA_I(SFR_WDATA_I),
  .SFR_RDATA_O(SFR_RDATA_O), .XM_WR_I(XM_WR_I), .XM_RD_I(XM_RD_I),
  .XM_SHORT_I(XM_SHORT_I), .XM_ADDR_I(XM_ADDR_I), .XM_WDATA_I(XM_WDATA_I),
  .XM_RVALID_O(XM_RVALID_O), .XM_FIFO_HIT_O(XM_FIFO_HIT_O),
  .MON_EN_I(MON_EN_I), .MON_RST_EN_I(MON_RST_EN_I), .FL_PROG_O(FL_PROG_O),
  .FL_ERASE_O(FL_ERASE_O), .FL_ADDR_O(FL_ADDR_O), .FL_DATA_O(FL_DATA_O),
  .FLASH_ERROR_RESET_O(FLASH_ERROR_RESET_O),
  .FLASH_WRITE_ENABLE_O(FLASH_WRITE_ENABLE_O),
  .FLASH_ERASE_ENABLE_O(FLASH_ERASE_ENABLE_O));
`default_nettype wire

// >>> testbench.sv
// testbench: register and external-move sequences against the router.
// assumes fixed one-cycle answers, so no handshake waits are needed.
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import mdmr_pkg::*;
  logic clk = 1'b0, rstn = 1'b0, sw = 1'b0, sr = 1'b0, xw = 1'b0, xr = 1'b0;
  logic xs = 1'b0, me = 1'b1, mre = 1'b1, xv, fh, fp, fe, ferr, fwe, fee;
  logic [7:0] sa = 8'h00, sd = 8'h00, xd = 8'h00, srd, xrd, fts, fd, np, ne;
  logic [15:0] xa = 16'h0000, fa;
  logic [15:0] ta [4] = '{16'h0000, 16'h03ff, 16'h0400, 16'h07ff};
  logic [7:0] td [4] = '{8'h11, 8'h22, 8'h33, 8'h44};
  int miscompares = 0, n_checks = 0;
  always #25 clk = ~clk;
  mdmr_router mdmr_router_i (.CLK_I(clk), .RESETN_I(rstn), .SFR_WR_I(sw),
    .SFR_RD_I(sr), .SFR_ADDR_I(sa), .SFR_WDATA_I(sd), .SFR_RDATA_O(srd),
    .XM_WR_I(xw), .XM_RD_I(xr), .XM_SHORT_I(xs), .XM_ADDR_I(xa),
    .XM_WDATA_I(xd), .XM_RDATA_O(xrd), .XM_RVALID_O(xv), .XM_FIFO_HIT_O(fh),
    .MON_EN_I(me), .MON_RST_EN_I(mre), .FL_PROG_O(fp), .FL_ERASE_O(fe),
    .FL_ADDR_O(fa), .FL_DATA_O(fd), .FLASH_ERROR_RESET_O(ferr),
    .FLASH_WRITE_ENABLE_O(fwe), .FLASH_ERASE_ENABLE_O(fee),
    .FLASH_TIMING_SCALE_O(fts));
  mdmr_flash_model mdmr_flash_model_i (.clk_i(clk), .prog_i(fp),
    .erase_i(fe), .n_prog_o(np), .n_erase_o(ne));
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic results;
    $display("checks=%0d miscompares=%0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // one strobe cycle; answers are looked at one edge later
  task automatic sfr(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk); #1;
    {sw, sr, sa, sd} = {w, !w, a, d};
    @(posedge clk); #1;
    {sw, sr} = 2'b00;
  endtask
  task automatic xm(input logic w, input logic s, input logic [15:0] a,
    input logic [7:0] d);
    @(posedge clk); #1;
    {xw, xr, xs, xa, xd} = {w, !w, s, a, d};
    @(posedge clk); #1;
    {xw, xr, xs} = 3'b000;
  endtask
  initial begin
    #1000000;
    miscompares++;
    results();
  end
  initial begin
    repeat (5) @(posedge clk);
    #1 rstn = 1'b1;
    sfr(1'b0, MDMR_PSC_ADDR, 8'h00); cmp(srd, MDMR_PSC_RESET);
    sfr(1'b1, MDMR_FTS_ADDR, 8'ha5); cmp(fts, 8'ha5);
    sfr(1'b1, MDMR_PSC_ADDR, 8'hfc); cmp(fwe | fee, 1'b0);
    sfr(1'b0, MDMR_PSC_ADDR, 8'h00); cmp(srd, 8'h00);
    for (int i = 0; i < 4; i++) begin
      xm(1'b1, 1'b0, ta[i], td[i]); cmp(fp | fe, 1'b0);
    end
    for (int i = 0; i < 4; i++) begin
      xm(1'b0, 1'b0, ta[i] | 16'hf800, 8'h00); cmp(xrd, td[i]);
      cmp({xv, fh}, {1'b1, ta[i][10]});
    end
    sfr(1'b1, MDMR_PAGE_ADDR, 8'hff);
    sfr(1'b0, MDMR_PAGE_ADDR, 8'h00); cmp(srd, 8'h07);
    xm(1'b0, 1'b1, 16'h12ff, 8'h00); cmp(xrd, 8'h44);
    cmp(fh, 1'b1);
    xm(1'b1, 1'b1, 16'hab10, 8'h66);
    xm(1'b0, 1'b0, 16'h0710, 8'h00); cmp(xrd, 8'h66);
    sfr(1'b1, MDMR_PSC_ADDR, 8'h01);
    xm(1'b1, 1'b0, 16'h0800, 8'h5a); cmp({fp, fe, fd}, 10'h25a);
    cmp(fa, 16'h0800);
    xm(1'b0, 1'b0, 16'h0000, 8'h00); cmp(xrd, 8'h11);
    sfr(1'b1, MDMR_PSC_ADDR, 8'h03);
    xm(1'b1, 1'b0, 16'h0a00, 8'h00); cmp({fp, fe}, 2'b01);
    cmp(fa, 16'h0a00);
    mre = 1'b0;
    xm(1'b1, 1'b0, 16'h0001, 8'h77); cmp({ferr, fp, fe}, 3'b100);
    cmp({np, ne}, 16'h0101);
    sfr(1'b0, MDMR_PSC_ADDR, 8'h00); cmp(srd, 8'h03);
    @(posedge clk);
    #1 rstn = 1'b0;
    @(posedge clk);
    #1 rstn = 1'b1;
    cmp({ferr, fwe, fee, fp, fe, xv, srd}, 14'h0000);
    @(posedge clk);
    #1 cmp({ferr, fwe, fee, fp, fe, xv}, 6'h00);
    results();
  end
endmodule
`default_nettype wire
